//--- uart_mp_pkg.sv
// constants shared by the serial port with multiprocessor addressing
package uart_mp_pkg;
   localparam int         SFR_W         = 8;
   localparam logic [7:0] CONTROL_ADDR  = 8'h98;
   localparam logic [7:0] DATA_ADDR     = 8'h99;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET    = 8'h00;
   localparam int         MODE_HI_BIT   = 7;
   localparam int         MODE_LO_BIT   = 6;
   localparam int         MP_EN_BIT     = 5;
   localparam int         RX_EN_BIT     = 4;
   localparam int         TX9_BIT       = 3;
   localparam int         RX9_BIT       = 2;
   localparam int         TX_FLAG_BIT   = 1;
   localparam int         RX_FLAG_BIT   = 0;
   // sixteen sample ticks per asynchronous bit
   localparam logic [3:0] TICK_LAST     = 4'hF;
   localparam logic [3:0] SAMPLE_TICK   = 4'h7;
   // fixed-rate mode: 64 or 32 clocks per bit, so 4 or 2 per tick
   localparam logic [3:0] FIX_DIV_SLOW  = 4'h4;
   localparam logic [3:0] FIX_DIV_FAST  = 4'h2;
   // synchronous mode: 12 clocks per bit, one tick per half bit
   localparam logic [3:0] SYNC_HALF_DIV = 4'h6;
   localparam logic [3:0] LAST_BIT_8    = 4'h7;
   localparam logic [3:0] LAST_BIT_9    = 4'h8;
   typedef enum logic [1:0] {
      MODE_SYNC = 2'b00,
      MODE_8BIT = 2'b01,
      MODE_9FIX = 2'b10,
      MODE_9VAR = 2'b11
   } mode_e;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_DATA  = 2'b11,
      ST_STOP  = 2'b10
   } frame_state_e;
endpackage

//--- tick_divider.sv
// free-running divider giving a one-cycle tick every i_div clocks
module tick_divider #(
   parameter int W = 4
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_run,
   input  wire logic [W-1:0] i_div,
   output logic              o_tick
);
   logic [W-1:0] cnt_reg;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_reg <= '0;
         o_tick  <= 1'b0;
      end
      else if (!i_run || cnt_reg >= i_div - W'(1))
      begin
         cnt_reg <= '0;
         o_tick  <= i_run;
      end
      else
      begin
         cnt_reg <= cnt_reg + W'(1);
         o_tick  <= 1'b0;
      end
   end
endmodule // tick_divider

//--- uart_multiprocessor_addressing.sv
// serial port: control register, split data buffer, nine-bit multiprocessor receive filter
module uart_multiprocessor_addressing (
   input  wire logic                          i_clk,
   input  wire logic                          i_rst,
   input  wire logic [uart_mp_pkg::SFR_W-1:0] i_sfr_addr,
   input  wire logic [uart_mp_pkg::SFR_W-1:0] i_sfr_wdata,
   input  wire logic                          i_sfr_wr,
   input  wire logic                          i_sfr_rd,
   input  wire logic [uart_mp_pkg::SFR_W-1:0] i_bit_addr,
   input  wire logic                          i_bit_wdata,
   input  wire logic                          i_bit_wr,
   input  wire logic                          i_timer1_ovf,
   input  wire logic                          i_baud_doubling,
   input  wire logic                          i_rxd,
   output logic [uart_mp_pkg::SFR_W-1:0]      o_sfr_rdata,
   output logic                               o_txd,
   output logic                               o_rxd_out,
   output logic                               o_rxd_oe_n,
   output logic                               o_transmit_flag,
   output logic                               o_receive_flag
);
   import uart_mp_pkg::*;

   logic [7:0]   control_reg;
   logic [7:0]   control_next;
   logic [7:0]   rx_buffer_reg;
   logic [8:0]   tx_shift_reg;
   logic [3:0]   tx_cnt_reg;
   logic [3:0]   tx_bits_reg;
   logic [8:0]   rx_shift_reg;
   logic [3:0]   rx_cnt_reg;
   logic [3:0]   rx_bits_reg;
   logic         tx_done_reg;
   logic         sync_rx_reg;
   logic         sync_rx_done_reg;
   logic         rx_load_reg;
   logic         rx9_val_reg;
   logic         rxd_prev_reg;
   logic         ovf_half_reg;
   logic         fix_tick;
   logic         h_tick;
   logic         s_tick;
   logic         rx_sample;
   logic         rx_accept;
   logic         rx_ninth;
   frame_state_e tx_state_reg;
   frame_state_e rx_state_reg;
   mode_e        mode;
   logic         nine_bit;
   logic         tx_start;
   logic [3:0]   last_bit;

   assign mode     = mode_e'(control_reg[MODE_HI_BIT:MODE_LO_BIT]);
   assign nine_bit = control_reg[MODE_HI_BIT];
   assign last_bit = nine_bit ? LAST_BIT_9 : LAST_BIT_8;
   assign tx_start = i_sfr_wr && i_sfr_addr == DATA_ADDR;

   //----------------------------------------
   // bit clocks
   //----------------------------------------
   tick_divider #(.W(4)) fix_div (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_run  (mode == MODE_9FIX),
      .i_div  (i_baud_doubling ? FIX_DIV_FAST : FIX_DIV_SLOW),
      .o_tick (fix_tick)
   );
   tick_divider #(.W(4)) sync_div (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_run  (mode == MODE_SYNC),
      .i_div  (SYNC_HALF_DIV),
      .o_tick (h_tick)
   );

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         ovf_half_reg <= 1'b0;
      else if (i_timer1_ovf)
         ovf_half_reg <= ~ovf_half_reg;
   end

   assign s_tick = (mode == MODE_9FIX) ? fix_tick
                 : (i_timer1_ovf && (i_baud_doubling || ovf_half_reg));

   //----------------------------------------
   // control register
   //----------------------------------------
   always_comb
   begin
      control_next = control_reg;
      if (i_sfr_wr && i_sfr_addr == CONTROL_ADDR)
         control_next = i_sfr_wdata;
      if (i_bit_wr && i_bit_addr[7:3] == CONTROL_ADDR[7:3])
         control_next[i_bit_addr[2:0]] = i_bit_wdata;
      if (rx_load_reg)
      begin
         control_next[RX9_BIT]     = rx9_val_reg;
         control_next[RX_FLAG_BIT] = 1'b1;
      end
      if (tx_done_reg)
         control_next[TX_FLAG_BIT] = 1'b1;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         control_reg     <= CONTROL_RESET;
         o_transmit_flag <= 1'b0;
         o_receive_flag  <= 1'b0;
      end
      else
      begin
         control_reg     <= control_next;
         o_transmit_flag <= control_next[TX_FLAG_BIT];
         o_receive_flag  <= control_next[RX_FLAG_BIT];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_sfr_rdata <= 8'h00;
      else if (i_sfr_rd)
         o_sfr_rdata <= (i_sfr_addr == CONTROL_ADDR) ? control_reg
                      : (i_sfr_addr == DATA_ADDR) ? rx_buffer_reg : 8'h00;
   end

   //----------------------------------------
   // transmitter and synchronous engine
   //----------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         tx_state_reg     <= ST_IDLE;
         tx_shift_reg     <= 9'h000;
         tx_cnt_reg       <= 4'h0;
         tx_bits_reg      <= 4'h0;
         tx_done_reg      <= 1'b0;
         sync_rx_reg      <= 1'b0;
         sync_rx_done_reg <= 1'b0;
         o_txd            <= 1'b1;
         o_rxd_out        <= 1'b1;
         o_rxd_oe_n       <= 1'b1;
      end
      else
      begin
         tx_done_reg      <= 1'b0;
         sync_rx_done_reg <= 1'b0;
         if (mode == MODE_SYNC)
         begin
            if (tx_start)
            begin
               tx_state_reg <= ST_DATA;
               sync_rx_reg  <= 1'b0;
               tx_shift_reg <= {1'b0, i_sfr_wdata};
               o_rxd_out    <= i_sfr_wdata[0];
               o_rxd_oe_n   <= 1'b0;
               o_txd        <= 1'b0;
               tx_bits_reg  <= 4'h0;
            end
            else if (tx_state_reg == ST_IDLE && control_reg[RX_EN_BIT] &&
                     !control_reg[RX_FLAG_BIT] && !sync_rx_done_reg && !rx_load_reg)
            begin
               tx_state_reg <= ST_DATA;
               sync_rx_reg  <= 1'b1;
               o_rxd_oe_n   <= 1'b1;
               o_txd        <= 1'b0;
               tx_bits_reg  <= 4'h0;
            end
            else if (tx_state_reg != ST_IDLE && h_tick)
            begin
               if (!o_txd)
               begin
                  // sample on the rising shift clock
                  o_txd <= 1'b1;
                  if (sync_rx_reg)
                     tx_shift_reg <= {1'b0, i_rxd, tx_shift_reg[7:1]};
               end
               else if (tx_bits_reg == LAST_BIT_8)
               begin
                  tx_state_reg <= ST_IDLE;
                  o_rxd_oe_n   <= 1'b1;
                  tx_done_reg      <= !sync_rx_reg;
                  sync_rx_done_reg <= sync_rx_reg;
               end
               else
               begin
                  o_txd       <= 1'b0;
                  tx_bits_reg <= tx_bits_reg + 4'h1;
                  if (!sync_rx_reg)
                  begin
                     tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
                     o_rxd_out    <= tx_shift_reg[1];
                  end
               end
            end
         end
         else
         begin
            o_rxd_oe_n <= 1'b1;
            if (tx_start)
            begin
               tx_shift_reg <= {control_reg[TX9_BIT], i_sfr_wdata};
               tx_state_reg <= ST_START;
               o_txd        <= 1'b0;
               tx_cnt_reg   <= 4'h0;
               tx_bits_reg  <= 4'h0;
            end
            else if (tx_state_reg != ST_IDLE && s_tick)
            begin
               tx_cnt_reg <= tx_cnt_reg + 4'h1;
               if (tx_cnt_reg == TICK_LAST)
               begin
                  case (tx_state_reg)
                     ST_START:
                     begin
                        tx_state_reg <= ST_DATA;
                        o_txd        <= tx_shift_reg[0];
                     end
                     ST_DATA:
                     begin
                        if (tx_bits_reg == last_bit)
                        begin
                           tx_state_reg <= ST_STOP;
                           o_txd        <= 1'b1;
                           tx_done_reg  <= 1'b1;
                        end
                        else
                        begin
                           tx_bits_reg  <= tx_bits_reg + 4'h1;
                           tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
                           o_txd        <= tx_shift_reg[1];
                        end
                     end
                     default:
                     begin
                        tx_state_reg <= ST_IDLE;
                        o_txd        <= 1'b1;
                     end
                  endcase
               end
            end
         end
      end
   end

   //----------------------------------------
   // asynchronous receiver
   //----------------------------------------
   assign rx_sample = s_tick && rx_cnt_reg == SAMPLE_TICK;
   assign rx_ninth  = nine_bit ? rx_shift_reg[8] : i_rxd;
   // ninth bit (stop bit in eight-bit mode) gate under mp enable
   // only the receive flag gates when mp enable clear
   assign rx_accept = !control_reg[RX_FLAG_BIT] && (!control_reg[MP_EN_BIT] || rx_ninth);

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rx_state_reg  <= ST_IDLE;
         rx_shift_reg  <= 9'h000;
         rx_cnt_reg    <= 4'h0;
         rx_bits_reg   <= 4'h0;
         rx_load_reg   <= 1'b0;
         rx9_val_reg   <= 1'b0;
         rx_buffer_reg <= DATA_RESET;
         rxd_prev_reg  <= 1'b1;
      end
      else
      begin
         rx_load_reg  <= 1'b0;
         rxd_prev_reg <= i_rxd;
         if (sync_rx_done_reg)
         begin
            rx_buffer_reg <= tx_shift_reg[7:0];
            rx9_val_reg   <= control_reg[RX9_BIT];
            rx_load_reg   <= 1'b1;
         end
         if (mode == MODE_SYNC || !control_reg[RX_EN_BIT])
            rx_state_reg <= ST_IDLE;
         else if (rx_state_reg == ST_IDLE)
         begin
            if (rxd_prev_reg && !i_rxd)
            begin
               rx_state_reg <= ST_START;
               rx_cnt_reg   <= 4'h0;
               rx_bits_reg  <= 4'h0;
            end
         end
         else if (s_tick)
         begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            case (rx_state_reg)
               ST_START:
               begin
                  if (rx_sample && i_rxd)
                     rx_state_reg <= ST_IDLE;
                  else if (rx_cnt_reg == TICK_LAST)
                     rx_state_reg <= ST_DATA;
               end
               ST_DATA:
               begin
                  if (rx_sample)
                     rx_shift_reg <= {i_rxd, rx_shift_reg[8:1]};
                  if (rx_cnt_reg == TICK_LAST)
                  begin
                     if (rx_bits_reg == last_bit)
                        rx_state_reg <= ST_STOP;
                     else
                        rx_bits_reg <= rx_bits_reg + 4'h1;
                  end
               end
               ST_STOP:
               begin
                  if (rx_sample)
                  begin
                     rx_state_reg <= ST_IDLE;
                     if (rx_accept)
                     begin
                        rx_buffer_reg <= nine_bit ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
                        rx9_val_reg   <= rx_ninth;
                        rx_load_reg   <= 1'b1;
                     end
                  end
               end
               default:
                  rx_state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   //----------------------------------------
   // assertions
   //----------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_stop_sample;
      rx_state_reg == ST_STOP && rx_sample && mode != MODE_SYNC && control_reg[RX_EN_BIT];
   endsequence
   sequence s_flag_set;
      rx_load_reg ##1 control_reg[RX_FLAG_BIT];
   endsequence

   property p_mp_filter;
      s_stop_sample and (nine_bit && control_reg[MP_EN_BIT] && !rx_shift_reg[8]) |=> !rx_load_reg;
   endproperty
   a_mp_filter: assert property (p_mp_filter) else $error("address filter let a data byte through");

   property p_mp_off;
      s_stop_sample and (!control_reg[MP_EN_BIT] && !control_reg[RX_FLAG_BIT]) |=> s_flag_set;
   endproperty
   a_mp_off: assert property (p_mp_off) else $error("byte lost with mp enable clear");

   property p_full_drop;
      s_stop_sample and control_reg[RX_FLAG_BIT] |=> !rx_load_reg;
   endproperty
   a_full_drop: assert property (p_full_drop) else $error("byte loaded over a set receive flag");

   property p_tx_start;
      tx_start && mode != MODE_SYNC |=> tx_state_reg == ST_START && !o_txd;
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("buffer write did not start a frame");

   property p_read_rx;
      i_sfr_rd && i_sfr_addr == DATA_ADDR |=> o_sfr_rdata == $past(rx_buffer_reg);
   endproperty
   a_read_rx: assert property (p_read_rx) else $error("data read did not return receive buffer");

   property p_bit_write;
      i_bit_wr && i_bit_addr == (CONTROL_ADDR | 8'h05) && !i_sfr_wr |=> control_reg[MP_EN_BIT] == $past(i_bit_wdata);
   endproperty
   a_bit_write: assert property (p_bit_write) else $error("bit write missed the control register");

   property p_ninth_tx;
      tx_start && mode != MODE_SYNC |=> tx_shift_reg[8] == $past(control_reg[TX9_BIT]);
   endproperty
   a_ninth_tx: assert property (p_ninth_tx) else $error("ninth transmit bit not framed");

   property p_tx_flag;
      tx_done_reg |-> ##1 control_reg[TX_FLAG_BIT] && o_transmit_flag;
   endproperty
   a_tx_flag: assert property (p_tx_flag) else $error("transmit flag not set at end of byte");

   property p_stop_level;
      tx_done_reg && mode != MODE_SYNC |-> o_txd && tx_state_reg == ST_STOP;
   endproperty
   a_stop_level: assert property (p_stop_level) else $error("flag set away from stop bit");

   property p_sync_drive;
      tx_start && mode == MODE_SYNC |=> !o_rxd_oe_n && o_rxd_out == $past(i_sfr_wdata[0]);
   endproperty
   a_sync_drive: assert property (p_sync_drive) else $error("synchronous send did not drive data pin");

   property p_doubled_rate;
      (mode == MODE_8BIT || mode == MODE_9VAR) && i_baud_doubling && i_timer1_ovf |-> s_tick;
   endproperty
   a_doubled_rate: assert property (p_doubled_rate) else $error("doubled rate skipped an overflow");
endmodule // uart_multiprocessor_addressing

//--- serial_peer.sv
// far-side serial port model: nine-bit frame sender and receiver
module serial_peer #(
   parameter int BIT_CLK = 32
) (
   input  wire logic       i_clk,
   input  wire logic       i_line,
   output logic            o_line,
   output logic [7:0]      o_got_data,
   output logic            o_got_ninth
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      o_line = 1'b1;
   end

   task automatic send(input logic [7:0] data, input logic ninth);
      logic [10:0] frame;
      frame = {1'b1, ninth, data, 1'b0};
      for (int i = 0; i < 11; i++)
      begin
         o_line <= frame[i];
         repeat (BIT_CLK) @(posedge i_clk);
      end
   endtask

   initial
   begin
      o_got_data = 8'h00;
      o_got_ninth = 1'b0;
      forever
      begin
         @(posedge i_clk);
         if (i_line === 1'b0)
         begin
            repeat (BIT_CLK / 2) @(posedge i_clk);
            for (int i = 0; i < 9; i++)
            begin
               repeat (BIT_CLK) @(posedge i_clk);
               if (i < 8)
                  o_got_data[i] <= i_line;
               else
                  o_got_ninth <= i_line;
            end
            repeat (BIT_CLK) @(posedge i_clk);
         end
      end
   end
endmodule // serial_peer

//--- uart_multiprocessor_addressing_tb.sv
// self-checking bench for the serial port with multiprocessor addressing
module uart_multiprocessor_addressing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import uart_mp_pkg::*;

   logic       clk, rst, sfr_wr, sfr_rd, bit_wdata, bit_wr, rxd, dbl, rxd_out, rxd_oe_n;
   logic       ovf = 1'b0;
   logic       txd, tflag, rflag, got_ninth;
   logic [7:0] addr, wdata, bit_addr, rdata, got_data;
   int         n_errors = 0;
   int         comparisons = 0;

   uart_multiprocessor_addressing uart_multiprocessor_addressing_i (
      .i_clk(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
      .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd), .i_bit_addr(bit_addr),
      .i_bit_wdata(bit_wdata), .i_bit_wr(bit_wr), .i_timer1_ovf(ovf),
      .i_baud_doubling(dbl), .i_rxd(rxd), .o_sfr_rdata(rdata), .o_txd(txd),
      .o_rxd_out(rxd_out), .o_rxd_oe_n(rxd_oe_n), .o_transmit_flag(tflag),
      .o_receive_flag(rflag));

   serial_peer serial_peer_i (
      .i_clk(clk), .i_line(txd), .o_line(rxd), .o_got_data(got_data),
      .o_got_ninth(got_ninth));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // overflow every second clock: one sample tick each while dbl is set, one per two overflows while it is clear
   always @(posedge clk) ovf <= ~ovf;

   // ----------------------------------------
   // bus and check tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask

   task automatic bwr(input logic [7:0] a, input logic v);
      @(posedge clk);
      bit_addr <= a;
      bit_wdata <= v;
      bit_wr <= 1'b1;
      @(posedge clk);
      bit_wr <= 1'b0;
   endtask

   task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1;
      chk(what, exp, rdata);
   endtask

   task automatic wait_flag(input logic rx);
      int n;
      n = 0;
      while (((rx ? rflag : tflag) !== 1'b1) && n < 1000)
      begin
         @(posedge clk);
         n++;
      end
      if (n == 1000)
      begin
         $display("wrong value flag wait expected 1 seen timeout");
         n_errors++;
         wrap_up();
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_values();
      rdc("control", CONTROL_ADDR, 8'h00);
      rdc("data", DATA_ADDR, 8'h00);
      rdc("unmapped", 8'h9A, 8'h00);
      chk("flags", 8'h00, {6'h00, tflag, rflag});
   endtask

   task automatic t_control();
      for (int m = 0; m < 4; m++)
      begin
         wr(CONTROL_ADDR, {2'(m), 6'h00});
         rdc("mode", CONTROL_ADDR, {2'(m), 6'h00});
      end
      wr(CONTROL_ADDR, 8'h00);
      wr(8'h9A, 8'hFF);
      bwr(8'h9D, 1'b1);
      rdc("bit write", CONTROL_ADDR, 8'h20);
      bwr(8'h9D, 1'b0);
   endtask

   task automatic t_transmit();
      wr(CONTROL_ADDR, 8'hC8);
      wr(DATA_ADDR, 8'hA5);
      rdc("rx not tx", DATA_ADDR, 8'h00);
      wait_flag(1'b0);
      chk("line at flag", 8'h01, {7'h00, txd});
      chk("sent byte", 8'hA5, got_data);
      chk("sent ninth", 8'h01, {7'h00, got_ninth});
      repeat (40) @(posedge clk);
      chk("flag held", 8'h01, {7'h00, tflag});
      bwr(8'h99, 1'b0);
      rdc("tx clear", CONTROL_ADDR, 8'hC8);
   endtask

   task automatic t_mp_receive();
      wr(CONTROL_ADDR, 8'hF0);
      serial_peer_i.send(8'h55, 1'b0);
      chk("data ignored", 8'h00, {7'h00, rflag});
      serial_peer_i.send(8'h3C, 1'b1);
      wait_flag(1'b1);
      rdc("address", DATA_ADDR, 8'h3C);
      rdc("rb8 set", CONTROL_ADDR, 8'hF5);
      bwr(8'h9D, 1'b0);
      bwr(8'h98, 1'b0);
      serial_peer_i.send(8'h66, 1'b0);
      wait_flag(1'b1);
      rdc("data byte", DATA_ADDR, 8'h66);
      rdc("rb8 clear", CONTROL_ADDR, 8'hD1);
      serial_peer_i.send(8'h77, 1'b1);
      rdc("overrun data", DATA_ADDR, 8'h66);
      rdc("overrun rb8", CONTROL_ADDR, 8'hD1);
   endtask

   task automatic t_rates();
      int n;
      n = 0;
      wr(CONTROL_ADDR, 8'h80);
      wr(DATA_ADDR, 8'hC3);
      wait_flag(1'b0);
      chk("fixed rate byte", 8'hC3, got_data);
      chk("fixed rate ninth", 8'h00, {7'h00, got_ninth});
      dbl <= 1'b0;
      wr(CONTROL_ADDR, 8'hC0);
      wr(DATA_ADDR, 8'h00);
      while (tflag !== 1'b1 && n < 1000)
      begin
         @(posedge clk);
         n++;
      end
      comparisons++;
      if (n < 636 || n > 644)
      begin
         $display("wrong value slow frame cycles expected 640 seen %0d", n);
         n_errors++;
      end
      dbl <= 1'b1;
      repeat (80) @(posedge clk);
   endtask

   task automatic t_sync();
      logic [7:0] got;
      int         bits;
      int         n;
      logic       prev;
      got = 8'h00;
      bits = 0;
      n = 0;
      prev = 1'b1;
      wr(CONTROL_ADDR, 8'h00);
      wr(DATA_ADDR, 8'h5A);
      while (tflag !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         n++;
         if (!prev && txd && !rxd_oe_n)
         begin
            got = {rxd_out, got[7:1]};
            bits++;
         end
         prev = txd;
      end
      chk("sync byte", 8'h5A, got);
      chk("sync bits", 8'h08, 8'(bits));
      chk("sync flag", 8'h01, {7'h00, tflag});
      chk("sync release", 8'h01, {7'h00, rxd_oe_n});
      wr(CONTROL_ADDR, 8'h10);
      wait_flag(1'b1);
      rdc("sync rx", DATA_ADDR, 8'hFF);
      rdc("sync rx control", CONTROL_ADDR, 8'h11);
   endtask

   initial
   begin
      rst = 1'b1;
      dbl = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      bit_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      bit_wdata = 1'b0;
      bit_wr = 1'b0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset_values();
      t_control();
      t_transmit();
      t_rates();
      t_sync();
      t_mp_receive();
      wrap_up();
   end
endmodule // uart_multiprocessor_addressing_tb
